// [tec_pkg.sv]
// Package: register map, field layout and types of the 8-bit timer/event counter
package tec_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_COUNT_PRELOAD   = 4'h0;
    localparam logic [3:0] ADDR_COUNTER_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS      = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ENABLE      = 4'h3;
    localparam logic [3:0] ADDR_IRQ_CLEAR       = 4'h4;

    // ------------------------------------------------------------
    // Control field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_MODE_HI   = 7;
    localparam int CTL_MODE_LO   = 6;
    localparam int CTL_SRC_BIT   = 5;
    localparam int CTL_EN_BIT    = 4;
    localparam int CTL_EDGE_BIT  = 3;
    localparam int CTL_PSC_HI    = 2;
    localparam int CTL_PSC_LO    = 0;
    localparam logic [7:0] COUNT_PRELOAD_RST   = 8'h00;
    localparam logic [7:0] COUNTER_CONTROL_RST = 8'h08;
    localparam logic [7:0] COUNT_MAX           = 8'hFF;

    // Interrupt status bit positions
    localparam int IRQ_OVF_BIT  = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_WIDTH    = 2;

    // Prescaler counter width (divide by up to 128)
    localparam int PSC_WIDTH = 7;

    typedef enum logic [1:0] {
        TEC_MODE_UNUSED = 2'b00,
        TEC_MODE_EVENT  = 2'b01,
        TEC_MODE_TIMER  = 2'b10,
        TEC_MODE_PULSE  = 2'b11
    } tec_mode_t;

    typedef struct packed {
        tec_mode_t  mode_select;
        logic       source_clock_select;
        logic       count_enable;
        logic       active_edge_select;
        logic [2:0] prescale_select;
    } tec_ctrl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tec_bus_req_t;

endpackage

// [tec_edge_sync.sv]
// Synchroniser and edge detector for the external count pin
`timescale 1ns/10ps
module tec_edge_sync (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      rise_out,
    output logic      fall_out,
    output logic      level_out
);
    logic sync1_r;
    logic sync2_r;
    logic last_r;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            last_r  <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            last_r  <= sync2_r;
        end
    end

    assign rise_out  = sync2_r & ~last_r;
    assign fall_out  = ~sync2_r & last_r;
    assign level_out = sync2_r;
endmodule

// [tec_prescaler.sv]
// Power-of-two prescaler producing one-cycle count ticks
`timescale 1ns/10ps
module tec_prescaler #(
    parameter int WIDTH = tec_pkg::PSC_WIDTH
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       src_tick_in,
    input  wire logic [2:0] psc_sel_in,
    output logic            tick_out
);
    logic [WIDTH-1:0] div_r;
    logic [WIDTH-1:0] mask;

    // Mask of low bits that must all be set for a tick
    assign mask = WIDTH'((1 << psc_sel_in) - 1);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            div_r <= '0;
        end else if (src_tick_in) begin
            div_r <= div_r + WIDTH'(1);
        end
    end

    assign tick_out = src_tick_in & ((div_r & mask) == mask);
endmodule

// [tec_timer.sv]
// Top: 8-bit timer/event counter with register port and interrupt
`timescale 1ns/10ps

// Summary of operation
// - One 8-bit up-counter, preloadable, internal or pin
// - Mode field: event, timer, pulse width
// - Timer/pulse use prescaler; source system or sub clock
// - Prescale divides by one to 128
// - Event mode counts chosen pin edges
// - Edge bit picks edge or pulse polarity
// - Pin counting ignores prescale and source settings
// - Count enable runs or halts counter
// - Overflow past FFH interrupts, reloads, continues
// - Write while disabled loads counter immediately
// - Write while enabled updates preload; overflow in same cycle reloads the written value
// - Count register reads running counter
// - Pulse mode enable only arms until edge
// - Pulse end clears enable, ignores further edges
module tec_timer (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       sub_clock_tick_in,
    input  wire logic       external_count_pin_in,
    output logic [7:0]      rdata_out,
    output logic            irq_out
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    tec_pkg::tec_bus_req_t          req;
    tec_pkg::tec_ctrl_t             ctrl_r;
    logic [7:0]                     preload_r;
    logic [7:0]                     count_r;
    logic                           running_r;
    logic [tec_pkg::IRQ_WIDTH-1:0]  irq_status_r;
    logic [tec_pkg::IRQ_WIDTH-1:0]  irq_enable_r;
    logic [7:0]                     rdata_r;
    logic                           irq_r;

    logic                           pin_rise;
    logic                           pin_fall;
    logic                           pin_level;
    logic                           psc_src;
    logic                           psc_tick;
    logic                           start_edge;
    logic                           stop_edge;
    logic                           count_tick;
    logic                           overflow;
    logic                           pulse_done;
    logic                           wr_count;
    logic                           wr_ctrl;
    tec_pkg::tec_mode_t             mode;

    assign req.addr  = addr_in;
    assign req.wdata = wdata_in;
    assign req.wr    = wr_in;
    assign req.rd    = rd_in;

    function automatic logic hit(input tec_pkg::tec_bus_req_t r,
                                 input logic [3:0] a);
        hit = (r.addr == a);
    endfunction

    assign wr_count = req.wr & hit(req, tec_pkg::ADDR_COUNT_PRELOAD);
    assign wr_ctrl  = req.wr & hit(req, tec_pkg::ADDR_COUNTER_CONTROL);
    assign mode     = ctrl_r.mode_select;

    // ------------------------------------------------------------
    // Pin and clock sources
    // ------------------------------------------------------------
    tec_edge_sync u_sync (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .pin_in    (external_count_pin_in),
        .rise_out  (pin_rise),
        .fall_out  (pin_fall),
        .level_out (pin_level)
    );

    // System clock ticks every cycle; sub clock arrives as a tick
    assign psc_src = ctrl_r.source_clock_select ? sub_clock_tick_in
                                                : 1'b1;

    tec_prescaler #(
        .WIDTH (tec_pkg::PSC_WIDTH)
    ) u_psc (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .src_tick_in (psc_src),
        .psc_sel_in  (ctrl_r.prescale_select),
        .tick_out    (psc_tick)
    );

    // Pulse polarity: edge bit 0 starts on fall, stops on rise
    assign start_edge = ctrl_r.active_edge_select ? pin_rise : pin_fall;
    assign stop_edge  = ctrl_r.active_edge_select ? pin_fall : pin_rise;

    // ------------------------------------------------------------
    // Count tick selection
    // ------------------------------------------------------------
    always_comb begin
        count_tick = 1'b0;
        unique case (mode)
            tec_pkg::TEC_MODE_EVENT: begin
                // Pin edges only; prescaler ignored
                count_tick = ctrl_r.count_enable & start_edge_event();
            end
            tec_pkg::TEC_MODE_TIMER: begin
                count_tick = ctrl_r.count_enable & psc_tick;
            end
            tec_pkg::TEC_MODE_PULSE: begin
                count_tick = ctrl_r.count_enable & running_r
                             & psc_tick & ~stop_edge;
            end
            tec_pkg::TEC_MODE_UNUSED: begin
                count_tick = 1'b0;
            end
        endcase
    end

    function automatic logic start_edge_event();
        // Edge bit 0 rising, 1 falling in event mode
        start_edge_event = ctrl_r.active_edge_select ? pin_fall : pin_rise;
    endfunction

    assign overflow   = count_tick & (count_r == tec_pkg::COUNT_MAX);
    assign pulse_done = (mode == tec_pkg::TEC_MODE_PULSE)
                        & ctrl_r.count_enable & running_r & stop_edge;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= tec_pkg::COUNTER_CONTROL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= req.wdata;
        end else if (pulse_done) begin
            ctrl_r.count_enable <= 1'b0;
        end
    end

    // Pulse mode armed versus running
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            running_r <= 1'b0;
        end else if (mode != tec_pkg::TEC_MODE_PULSE
                     || !ctrl_r.count_enable || pulse_done) begin
            running_r <= 1'b0;
        end else if (start_edge) begin
            running_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Preload and counter
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            preload_r <= tec_pkg::COUNT_PRELOAD_RST;
        end else if (wr_count) begin
            preload_r <= req.wdata;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= tec_pkg::COUNT_PRELOAD_RST;
        end else if (wr_count && !ctrl_r.count_enable) begin
            count_r <= req.wdata;
        end else if (overflow) begin
            count_r <= wr_count ? req.wdata : preload_r;
        end else if (count_tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, enable and clear
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_enable_r <= '0;
        end else if (req.wr && hit(req, tec_pkg::ADDR_IRQ_ENABLE)) begin
            irq_enable_r <= req.wdata[tec_pkg::IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_status_r <= '0;
        end else begin
            // Set wins over a clear in the same cycle
            irq_status_r <= (irq_status_r
                & ~((req.wr && hit(req, tec_pkg::ADDR_IRQ_CLEAR))
                    ? req.wdata[tec_pkg::IRQ_WIDTH-1:0]
                    : {tec_pkg::IRQ_WIDTH{1'b0}}))
                | {pulse_done, overflow};
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_status_r & irq_enable_r);
        end
    end
    assign irq_out = irq_r;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                tec_pkg::ADDR_COUNT_PRELOAD:   rdata_r <= count_r;
                tec_pkg::ADDR_COUNTER_CONTROL: rdata_r <= ctrl_r;
                tec_pkg::ADDR_IRQ_STATUS:
                    rdata_r <= {6'h00, irq_status_r};
                tec_pkg::ADDR_IRQ_ENABLE:
                    rdata_r <= {6'h00, irq_enable_r};
                default:                       rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata_out = rdata_r;

    // Level of synchronised pin kept for future use is unused here
    logic unused_level;
    assign unused_level = pin_level;
endmodule

// [tec_timer_asserts.sv]
// Checker: bus, reset and interrupt properties of the timer top
`timescale 1ns/10ps
module tec_timer_chk (
    input wire logic       clock_in,
    input wire logic       rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic       sub_clock_tick_in,
    input wire logic       external_count_pin_in,
    input wire logic [7:0] rdata_out,
    input wire logic       irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [1:0] ena_sh_r;
    logic       touched_r;
    // ------------------------------------------------------------
    // Shadow of interrupt enable and of count/control writes
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ena_sh_r <= 2'h0;
        end else if (wr_in && addr_in == tec_pkg::ADDR_IRQ_ENABLE) begin
            ena_sh_r <= wdata_in[1:0];
        end
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            touched_r <= 1'b0;
        end else if (wr_in && addr_in <= tec_pkg::ADDR_COUNTER_CONTROL) begin
            touched_r <= 1'b1;
        end
    end
    sequence s_rd(logic [3:0] a);
        rd_in && addr_in == a;
    endsequence
    sequence s_ctrl_off;
        wr_in && addr_in == tec_pkg::ADDR_COUNTER_CONTROL && !wdata_in[4];
    endsequence
    sequence s_cnt_wr;
        wr_in && addr_in == tec_pkg::ADDR_COUNT_PRELOAD;
    endsequence
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd_in && addr_in > 4'h4 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_clear_reads_zero: assert property (s_rd(4'h4) |=> rdata_out == 8'h00)
        else $error("clear register read not zero");
    a_ctrl_readback: assert property (s_ctrl_off ##2 s_rd(4'h1) |=> rdata_out == $past(wdata_in, 3))
        else $error("control readback wrong");
    a_load_when_off: assert property (s_ctrl_off ##2 s_cnt_wr ##2 s_rd(4'h0) |=> rdata_out == $past(wdata_in, 3))
        else $error("count not loaded while halted");
    a_ctrl_reset_val: assert property (rd_in && addr_in == 4'h1 && !touched_r |=> rdata_out == tec_pkg::COUNTER_CONTROL_RST)
        else $error("control reset value wrong");
    a_count_reset_val: assert property (rd_in && addr_in == 4'h0 && !touched_r |=> rdata_out == tec_pkg::COUNT_PRELOAD_RST)
        else $error("count reset value wrong");
    a_irq_needs_enable: assert property (irq_out |-> $past(ena_sh_r) != 2'h0)
        else $error("interrupt without enable");
    a_irq_mask_off: assert property (wr_in && addr_in == 4'h3 && wdata_in[1:0] == 2'h0 |-> ##2 !irq_out)
        else $error("interrupt not masked");
endmodule
bind tec_timer tec_timer_chk tec_timer_chk_inst (.clock_in(clock_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .sub_clock_tick_in(sub_clock_tick_in), .irq_out(irq_out),
    .external_count_pin_in(external_count_pin_in), .rdata_out(rdata_out));

// [tec_pin_model.sv]
// Pulse source model driving the external count pin
`timescale 1ns/10ps
module tec_pin_model (
    input  wire logic       clock_in,
    input  wire logic       idle_in,
    input  wire logic       go_in,
    input  wire logic [7:0] count_in,
    input  wire logic [7:0] width_in,
    output logic            pin_out,
    output logic            busy_out
);
    initial begin
        pin_out = 1'b0;
        busy_out = 1'b0;
    end
    // Burst of pulses, each level held width cycles
    always @(posedge clock_in) begin
        if (go_in && !busy_out) begin
            busy_out <= 1'b1;
            for (int k = 0; k < count_in; k++) begin
                pin_out <= ~idle_in;
                repeat (width_in) @(posedge clock_in);
                pin_out <= idle_in;
                repeat (width_in) @(posedge clock_in);
            end
            busy_out <= 1'b0;
        end else begin
            pin_out <= idle_in;
        end
    end
endmodule

// [tec_timer_tb_top.sv]
// Testbench: timer/event counter with external pulse source
`timescale 1ns/10ps
module tec_timer_tb_top;
    localparam logic [3:0] A_CNT = tec_pkg::ADDR_COUNT_PRELOAD;
    localparam logic [3:0] A_CTL = tec_pkg::ADDR_COUNTER_CONTROL;
    logic        clock_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  addr_in = 4'h0;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        sub_clock_tick_in = 1'b0;
    logic        external_count_pin_in;
    logic [7:0]  rdata_out;
    logic        irq_out;
    logic        idle_lvl = 1'b0;
    logic        go = 1'b0;
    logic [7:0]  n_pulse = 8'h01;
    logic [7:0]  width = 8'h04;
    logic        src_busy;
    logic [1:0]  sub_div = 2'h0;
    logic [31:0] seed = 32'h62873563;
    logic [7:0]  v;
    logic [7:0]  pre;
    logic [7:0]  n;
    int          err_total = 0;
    int          cmp_count = 0;

    always #50 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        sub_div <= sub_div + 2'h1;
        sub_clock_tick_in <= (sub_div == 2'h3);
    end
    tec_timer tec_timer_inst (.clock_in(clock_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .sub_clock_tick_in(sub_clock_tick_in), .irq_out(irq_out),
        .external_count_pin_in(external_count_pin_in), .rdata_out(rdata_out));
    tec_pin_model tec_pin_model_inst (.clock_in(clock_in), .idle_in(idle_lvl),
        .go_in(go), .count_in(n_pulse), .width_in(width),
        .pin_out(external_count_pin_in), .busy_out(src_busy));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] evt_exp(input logic [7:0] p, input logic [7:0] k);
        logic [7:0] c;
        c = p;
        for (int i = 0; i < k; i++) c = (c == 8'hFF) ? p : c + 8'h01;
        return c;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("ERROR %0t got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        d = rdata_out;
        @(posedge clock_in);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task automatic chk_irq(input logic x);
        @(negedge clock_in);
        chk({7'h00, irq_out}, {7'h00, x});
        @(posedge clock_in);
    endtask
    task automatic pulses(input logic [7:0] k, input logic [7:0] w);
        n_pulse <= k;
        width <= w;
        go <= 1'b1;
        @(posedge clock_in);
        go <= 1'b0;
        for (int i = 0; i < 4000 && (src_busy !== 1'b0 || i < 2); i++) @(posedge clock_in);
        repeat (4) @(posedge clock_in);
    endtask
    task automatic results;
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        results();
    end
    initial begin
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        rdchk(A_CNT, tec_pkg::COUNT_PRELOAD_RST);
        rdchk(A_CTL, tec_pkg::COUNTER_CONTROL_RST);
        rdchk(4'h7, 8'h00);
        rdchk(4'h4, 8'h00);
        for (int m = 0; m < 4; m++) begin
            seed = lfsr(seed);
            pre = {m[1:0], seed[5], 1'b0, seed[3:0]};
            wr(A_CTL, pre);
            rdchk(A_CTL, pre);
        end
        seed = lfsr(seed);
        wr(A_CTL, 8'h40);
        wr(A_CNT, seed[7:0]);
        rdchk(A_CNT, seed[7:0]);
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 8; p++) begin
                wr(A_CTL, {2'b10, s[0], 2'b00, p[2:0]});
                wr(A_CNT, 8'h00);
                wr(A_CTL, {2'b10, s[0], 2'b10, p[2:0]});
                repeat (198) @(posedge clock_in);
                wr(A_CTL, {2'b10, s[0], 2'b00, p[2:0]});
                rd(A_CNT, v);
                pre = 8'((s == 0 ? 200 : 50) >> p);
                chk_rng(v, (pre > 8'h03) ? pre - 8'h03 : 8'h00, pre + 8'h03);
                repeat (20) @(posedge clock_in);
                rdchk(A_CNT, v);
            end
        end
        wr(4'h3, 8'h03);
        for (int e = 0; e < 2; e++) begin
            seed = lfsr(seed);
            pre = {5'h1F, seed[2:0]};
            n = 8'h08 + {3'h0, seed[12:8]};
            wr(A_CTL, {2'b01, 2'b10, e[0], 3'h7});
            idle_lvl <= e[0];
            wr(A_CNT, pre);
            wr(A_CTL, {2'b01, 2'b11, e[0], 3'h7});
            pulses(n, 8'h03);
            idle_lvl <= ~e[0];
            repeat (6) @(posedge clock_in);
            rdchk(A_CNT, evt_exp(pre, n + 8'h01));
            rdchk(4'h2, 8'h01);
            chk_irq(1'b1);
            wr(4'h3, 8'h00);
            chk_irq(1'b0);
            wr(4'h3, 8'h03);
            wr(4'h4, 8'h03);
            chk_irq(1'b0);
        end
        for (int e = 0; e < 2; e++) begin
            wr(A_CTL, {2'b11, 2'b00, e[0], 3'h0});
            idle_lvl <= ~e[0];
            wr(A_CNT, 8'h00);
            wr(A_CTL, {2'b11, 2'b01, e[0], 3'h0});
            repeat (20) @(posedge clock_in);
            rdchk(A_CNT, 8'h00);
            seed = lfsr(seed);
            n = 8'h20 + {3'h0, seed[4:0]};
            pulses(8'h01, n);
            rd(A_CNT, v);
            chk_rng(v, n - 8'h03, n + 8'h03);
            rdchk(A_CTL, {2'b11, 2'b00, e[0], 3'h0});
            rdchk(4'h2, 8'h02);
            pulses(8'h01, n);
            rdchk(A_CNT, v);
            wr(4'h4, 8'h03);
        end
        results();
    end
endmodule
